// ---- design/lbc_cfg_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "lbc_defines.svh"
module lbc_cfg_regs
   import lbc_pkg::*;
(
   // clock, reset, enable
   input  wire logic        i_mclk,
   input  wire logic        i_rstn,
   input  wire logic        i_ce,
   // serial bus pins
   input  wire logic        i_scl,
   input  wire logic        i_sda,
   output logic             o_sda_out,
   output logic             o_sda_oen_n,
   // configuration to the driver core
   output lbc_cfg_t         o_cfg,
   output lbc_ramp_t [1:0]  o_ramp,
   output logic [10:0]      o_bank_a_brightness,
   output logic             o_bright_load
);

   // reset synchroniser
   logic [1:0]   rst_sync_q;     // release pipeline
   logic         rst_n;          // synchronised reset

   // serial engine state
   lbc_pin_evt_t evt;            // synced pin events
   lbc_state_t   state_q;
   lbc_state_t   state_d;
   lbc_state_t   nxt_q;          // state after the ack bit
   lbc_state_t   nxt_d;
   logic [3:0]   cnt_q;          // bits of current byte
   logic [3:0]   cnt_d;
   logic [7:0]   sh_q;           // shift register
   logic [7:0]   sh_d;
   logic [7:0]   ptr_q;          // register pointer
   logic [7:0]   ptr_d;
   logic         nack_q;         // master refused more read data
   logic         nack_d;
   logic         oen_n_q;        // low = pull sda low
   logic         oen_n_d;
   logic         sda_out_q;      // open drain: always drives zero

   // register file
   lbc_cfg_t     cfg_q;
   lbc_cfg_t     cfg_d;
   logic [2:0]   bright_lo_q;    // staged low bits
   logic [2:0]   bright_lo_d;
   logic [10:0]  bright_q;       // committed brightness
   logic [10:0]  bright_d;
   logic         load_q;
   lbc_ramp_t [1:0] ramp_q;
   lbc_ramp_t [1:0] ramp_d;

   // decode
   logic         byte_done;      // eight bits clocked in or out
   logic         addr_hit;       // target address matches
   logic         wr_stb;         // data byte written to ptr_q
   logic [7:0]   wdata;
   logic [7:0]   rd_byte;        // read mux output

   // release reset two edges after the pin rises
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // pin synchronisers and edge detection
   lbc_pin_sync u_pin_sync (
      .i_clk   (i_mclk),
      .i_rst_n (rst_n),
      .i_ce    (i_ce),
      .i_scl   (i_scl),
      .i_sda   (i_sda),
      .o_evt   (evt)
   );

   assign byte_done = (cnt_q == 4'h8);
   assign addr_hit  = (sh_q[7:1] == `LBC_TARGET_ADDR);
   assign wdata     = sh_q;
   // write only on the falling edge closing a data byte
   assign wr_stb    = i_ce & evt.scl_fall & ~evt.start & ~evt.stop
                      & (state_q == ST_WR) & byte_done;

   // serial slave: address, register pointer, then data bytes
   always_comb begin
      state_d = state_q;
      nxt_d   = nxt_q;
      cnt_d   = cnt_q;
      sh_d    = sh_q;
      ptr_d   = ptr_q;
      nack_d  = nack_q;
      oen_n_d = oen_n_q;
      if (evt.stop) begin
         // stop always frees the bus
         state_d = ST_IDLE;
         oen_n_d = 1'b1;
      end else if (evt.start) begin
         // start and repeated start behave alike
         state_d = ST_DEV;
         cnt_d   = 4'h0;
         oen_n_d = 1'b1;
      end else if (evt.scl_rise) begin
         case (state_q)
            ST_DEV, ST_REG, ST_WR: begin
               sh_d  = {sh_q[6:0], evt.sda};
               cnt_d = cnt_q + 4'h1;
            end
            ST_RD: cnt_d = cnt_q + 4'h1;
            ST_MACK: nack_d = evt.sda;
            default: ;
         endcase
      end else if (evt.scl_fall) begin
         case (state_q)
            ST_DEV: begin
               if (byte_done && addr_hit) begin
                  oen_n_d = 1'b0;
                  state_d = ST_ACK;
                  nxt_d   = sh_q[0] ? ST_RD : ST_REG;
               end else if (byte_done) begin
                  // another target: stay off the bus until next start
                  state_d = ST_IDLE;
               end
            end
            ST_REG: begin
               if (byte_done) begin
                  ptr_d   = sh_q;
                  oen_n_d = 1'b0;
                  state_d = ST_ACK;
                  nxt_d   = ST_WR;
               end
            end
            ST_WR: begin
               if (byte_done) begin
                  // further bytes go to the next offset
                  ptr_d   = ptr_q + 8'h01;
                  oen_n_d = 1'b0;
                  state_d = ST_ACK;
                  nxt_d   = ST_WR;
               end
            end
            ST_ACK: begin
               // end of ack bit: release, or present first read bit
               state_d = nxt_q;
               cnt_d   = 4'h0;
               oen_n_d = 1'b1;
               if (nxt_q == ST_RD) begin
                  sh_d    = rd_byte;
                  oen_n_d = rd_byte[7];
                  ptr_d   = ptr_q + 8'h01;
               end
            end
            ST_RD: begin
               if (byte_done) begin
                  state_d = ST_MACK;
                  oen_n_d = 1'b1;
               end else begin
                  sh_d    = {sh_q[6:0], 1'b0};
                  oen_n_d = sh_q[6];
               end
            end
            ST_MACK: begin
               if (nack_q) begin
                  state_d = ST_IDLE;
               end else begin
                  state_d = ST_RD;
                  cnt_d   = 4'h0;
                  sh_d    = rd_byte;
                  oen_n_d = rd_byte[7];
                  ptr_d   = ptr_q + 8'h01;
               end
            end
            default: state_d = ST_IDLE;
         endcase
      end
   end

   // serial engine registers
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q   <= ST_IDLE;
         nxt_q     <= ST_IDLE;
         cnt_q     <= 4'h0;
         sh_q      <= 8'h00;
         ptr_q     <= 8'h00;
         nack_q    <= 1'b1;
         oen_n_q   <= 1'b1;
         sda_out_q <= 1'b0;
      end else if (i_ce) begin
         state_q   <= state_d;
         nxt_q     <= nxt_d;
         cnt_q     <= cnt_d;
         sh_q      <= sh_d;
         ptr_q     <= ptr_d;
         nack_q    <= nack_d;
         oen_n_q   <= oen_n_d;
         sda_out_q <= 1'b0;
      end
   end

   // register writes; reserved bits are simply not stored
   always_comb begin
      cfg_d       = cfg_q;
      bright_lo_d = bright_lo_q;
      bright_d    = bright_q;
      if (wr_stb) begin
         case (ptr_q)
            `LBC_OFS_SINK:      cfg_d.sink_bank = wdata[2:0];
            `LBC_OFS_RAMP_A:    cfg_d.ramp_a = wdata;
            `LBC_OFS_RAMP_B:    cfg_d.ramp_b = wdata;
            `LBC_OFS_RT_RAMP:   cfg_d.rt_ramp = wdata;
            `LBC_OFS_RT_SEL:    cfg_d.rt_sel = wdata[3:0];
            `LBC_OFS_BRIGHT_OPT: begin
               cfg_d.dither_off_b = wdata[`LBC_BIT_DITHER_B];
               cfg_d.dither_off_a = wdata[`LBC_BIT_DITHER_A];
               cfg_d.map_linear   = wdata[`LBC_BIT_MAP_LINEAR];
            end
            `LBC_OFS_FULL_A:    cfg_d.full_scale_a = wdata[4:0];
            `LBC_OFS_FULL_B:    cfg_d.full_scale_b = wdata[4:0];
            `LBC_OFS_FEEDBACK:  cfg_d.feedback_en = wdata[2:0];
            `LBC_OFS_BOOST: begin
               cfg_d.auto_headroom   = wdata[`LBC_BIT_AUTO_HR];
               cfg_d.auto_freq       = wdata[`LBC_BIT_AUTO_FREQ];
               cfg_d.overvoltage_sel = wdata[2:1];
               cfg_d.freq_1mhz       = wdata[`LBC_BIT_FREQ_1MHZ];
            end
            `LBC_OFS_AF_THRESH: cfg_d.af_thresh = wdata;
            `LBC_OFS_PWM: begin
               // host is expected to touch this only with pwm idle
               cfg_d.zero_det     = wdata[`LBC_BIT_ZERO_DET];
               cfg_d.pwm_act_high = wdata[`LBC_BIT_PWM_POL];
               cfg_d.pwm_scale_b  = wdata[`LBC_BIT_PWM_B];
               cfg_d.pwm_scale_a  = wdata[`LBC_BIT_PWM_A];
            end
            // low write only stages bits; current is untouched
            `LBC_OFS_BRIGHT_LO: bright_lo_d = wdata[2:0];
            // high write commits the full value; low must come first
            `LBC_OFS_BRIGHT_HI: bright_d = {wdata, bright_lo_q};
            default: ;
         endcase
      end
   end

   // register file flops
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q       <= LBC_CFG_RST;
         bright_lo_q <= 3'h0;
         bright_q    <= 11'h000;
         load_q      <= 1'b0;
         ramp_q      <= {2{`LBC_RAMP_US_C0, `LBC_RAMP_US_C0}};
      end else if (i_ce) begin
         cfg_q       <= cfg_d;
         bright_lo_q <= bright_lo_d;
         bright_q    <= bright_d;
         load_q      <= wr_stb & (ptr_q == `LBC_OFS_BRIGHT_HI);
         ramp_q      <= ramp_d;
      end
   end

   // read mux; unmapped offsets and reserved bits read zero
   assign rd_byte =
      (ptr_q == `LBC_OFS_SINK)       ? {5'h00, cfg_q.sink_bank} :
      (ptr_q == `LBC_OFS_RAMP_A)     ? cfg_q.ramp_a :
      (ptr_q == `LBC_OFS_RAMP_B)     ? cfg_q.ramp_b :
      (ptr_q == `LBC_OFS_RT_RAMP)    ? cfg_q.rt_ramp :
      (ptr_q == `LBC_OFS_RT_SEL)     ? {4'h0, cfg_q.rt_sel} :
      (ptr_q == `LBC_OFS_BRIGHT_OPT) ? {4'h0, cfg_q.dither_off_b, cfg_q.dither_off_a,
                                        1'b0, cfg_q.map_linear} :
      (ptr_q == `LBC_OFS_FULL_A)     ? {3'h0, cfg_q.full_scale_a} :
      (ptr_q == `LBC_OFS_FULL_B)     ? {3'h0, cfg_q.full_scale_b} :
      (ptr_q == `LBC_OFS_FEEDBACK)   ? {5'h00, cfg_q.feedback_en} :
      (ptr_q == `LBC_OFS_BOOST)      ? {3'h0, cfg_q.auto_headroom, cfg_q.auto_freq,
                                        cfg_q.overvoltage_sel, cfg_q.freq_1mhz} :
      (ptr_q == `LBC_OFS_AF_THRESH)  ? cfg_q.af_thresh :
      (ptr_q == `LBC_OFS_PWM)        ? {4'h0, cfg_q.zero_det, cfg_q.pwm_act_high,
                                        cfg_q.pwm_scale_b, cfg_q.pwm_scale_a} :
      (ptr_q == `LBC_OFS_BRIGHT_LO)  ? {5'h00, bright_lo_q} :
      (ptr_q == `LBC_OFS_BRIGHT_HI)  ? bright_q[10:3] : 8'h00;

   // effective run-time ramp per bank
   for (genvar g = 0; g < 2; g++) begin : g_bank
      logic [1:0] sel;           // this bank's ramp select
      logic [7:0] own;           // this bank's start-up/shutdown codes
      logic [7:0] pick;          // codes in force
      assign sel  = cfg_q.rt_sel[2*g +: 2];
      assign own  = (g == 0) ? cfg_q.ramp_a : cfg_q.ramp_b;
      assign pick = (sel == 2'b01) ? own : cfg_q.rt_ramp;
      // select 1x gives an instant change
      assign ramp_d[g].up_us   = sel[1] ? 27'h0 : lbc_ramp_us(pick[7:4]);
      assign ramp_d[g].down_us = sel[1] ? 27'h0 : lbc_ramp_us(pick[3:0]);
   end

   // outputs straight from flops
   assign o_sda_out           = sda_out_q;
   assign o_sda_oen_n         = oen_n_q;
   assign o_cfg               = cfg_q;
   assign o_ramp              = ramp_q;
   assign o_bank_a_brightness = bright_q;
   assign o_bright_load       = load_q;

   // checks
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!rst_n);

   a_sink_write: assert property (wr_stb && ptr_q == `LBC_OFS_SINK |=>
      o_cfg.sink_bank == $past(wdata[2:0])) else $error("sink bank not stored");
   a_own_ramp: assert property (i_ce && cfg_q.rt_sel[3:2] == 2'b01 |=>
      o_ramp[1].down_us == lbc_ramp_us($past(cfg_q.ramp_b[3:0])))
      else $error("bank b own ramp wrong");
   a_code_zero: assert property (i_ce && cfg_q.rt_sel[1:0] == 2'b00
      && cfg_q.rt_ramp[7:4] == 4'h0 |=> o_ramp[0].up_us == 27'h800)
      else $error("code zero not 2048 us");
   a_shared_ramp: assert property (i_ce && cfg_q.rt_sel[1:0] == 2'b00 |=>
      o_ramp[0].up_us == lbc_ramp_us($past(cfg_q.rt_ramp[7:4])))
      else $error("shared ramp wrong");
   a_instant_ramp: assert property (i_ce && cfg_q.rt_sel[1] |=>
      o_ramp[0].up_us == 27'h0 && o_ramp[0].down_us == 27'h0)
      else $error("instant ramp not zero");
   a_opt_write: assert property (wr_stb && ptr_q == `LBC_OFS_BRIGHT_OPT |=>
      {o_cfg.dither_off_b, o_cfg.dither_off_a, o_cfg.map_linear}
      == {$past(wdata[3]), $past(wdata[2]), $past(wdata[0])})
      else $error("brightness options wrong");
   a_full_scale: assert property (wr_stb && ptr_q == `LBC_OFS_FULL_A |=>
      o_cfg.full_scale_a == $past(wdata[4:0])) else $error("full scale wrong");
   a_feedback_en: assert property (wr_stb && ptr_q == `LBC_OFS_FEEDBACK |=>
      o_cfg.feedback_en == $past(wdata[2:0])) else $error("feedback wrong");
   a_boost_fields: assert property (wr_stb && ptr_q == `LBC_OFS_BOOST |=>
      {o_cfg.auto_headroom, o_cfg.auto_freq, o_cfg.overvoltage_sel,
       o_cfg.freq_1mhz} == $past(wdata[4:0])) else $error("boost wrong");
   a_af_thresh: assert property (wr_stb && ptr_q == `LBC_OFS_AF_THRESH |=>
      o_cfg.af_thresh == $past(wdata)) else $error("threshold wrong");
   a_pwm_fields: assert property (wr_stb && ptr_q == `LBC_OFS_PWM |=>
      {o_cfg.zero_det, o_cfg.pwm_act_high, o_cfg.pwm_scale_b,
       o_cfg.pwm_scale_a} == $past(wdata[3:0])) else $error("pwm wrong");
   a_high_commit: assert property (wr_stb && ptr_q == `LBC_OFS_BRIGHT_HI |=>
      o_bank_a_brightness == {$past(wdata), $past(bright_lo_q)} && o_bright_load)
      else $error("brightness not committed");
   a_low_no_effect: assert property (wr_stb && ptr_q == `LBC_OFS_BRIGHT_LO |=>
      $stable(o_bank_a_brightness) && !o_bright_load)
      else $error("low write changed brightness");
   a_addr_ack: assert property (i_ce && evt.scl_fall && !evt.start && !evt.stop
      && state_q == ST_DEV && byte_done |=> o_sda_oen_n == !$past(addr_hit))
      else $error("address ack wrong");
   a_reserved_zero: assert property (ptr_q == `LBC_OFS_BRIGHT_OPT |->
      rd_byte[7:4] == 4'h0 && rd_byte[1] == 1'b0) else $error("reserved not zero");

   c_high_write: cover property (wr_stb && ptr_q == `LBC_OFS_BRIGHT_HI);
   c_read_byte:  cover property (state_q == ST_ACK && nxt_q == ST_RD ##1 state_q == ST_RD);
   c_instant:    cover property (cfg_q.rt_sel == 4'ha);
   c_other_dev:  cover property (state_q == ST_DEV ##1 state_q == ST_IDLE);

endmodule : lbc_cfg_regs
`default_nettype wire

// ---- design/lbc_defines.svh ----
// How it works
// - sink bit 0 bank A, 1 bank B
// - per-bank ramp: high nibble start-up, low shutdown
// - ramp code maps to sixteen fixed durations
// - shared run-time ramp: high up, low down
// - per-bank select: shared, own, or instant
// - dither disable bits 3 (B), 2 (A)
// - bit 0 selects exponential or linear mapping
// - five-bit full-scale current code per bank
// - feedback enable per string, default tied
// - boost bits 2:1 pick overvoltage threshold
// - boost bit 0 picks switching frequency
// - boost bits 4,3 auto headroom, auto frequency
// - eight-bit auto-frequency threshold, reset 0xcf
// - pwm bit 3 zero detection, default on
// - pwm bit 2 polarity, default active high
// - pwm bits 1,0 scale bank B, A
// - bank A brightness split low/high registers
// - only high write commits brightness
// - serial target 0x36, register then data byte
`ifndef LBC_DEFINES_SVH
`define LBC_DEFINES_SVH

// serial target address
`define LBC_TARGET_ADDR     7'h36

// register offsets
`define LBC_OFS_SINK        8'h10
`define LBC_OFS_RAMP_A      8'h11
`define LBC_OFS_RAMP_B      8'h12
`define LBC_OFS_RT_RAMP     8'h13
`define LBC_OFS_RT_SEL      8'h14
`define LBC_OFS_BRIGHT_OPT  8'h16
`define LBC_OFS_FULL_A      8'h17
`define LBC_OFS_FULL_B      8'h18
`define LBC_OFS_FEEDBACK    8'h19
`define LBC_OFS_BOOST       8'h1a
`define LBC_OFS_AF_THRESH   8'h1b
`define LBC_OFS_PWM         8'h1c
`define LBC_OFS_BRIGHT_LO   8'h20
`define LBC_OFS_BRIGHT_HI   8'h21

// field positions
`define LBC_BIT_DITHER_B    3
`define LBC_BIT_DITHER_A    2
`define LBC_BIT_MAP_LINEAR  0
`define LBC_BIT_AUTO_HR     4
`define LBC_BIT_AUTO_FREQ   3
`define LBC_BIT_FREQ_1MHZ   0
`define LBC_BIT_ZERO_DET    3
`define LBC_BIT_PWM_POL     2
`define LBC_BIT_PWM_B       1
`define LBC_BIT_PWM_A       0

// reset values of non-zero fields
`define LBC_RST_SINK        3'h6
`define LBC_RST_FULL_SCALE  5'h13
`define LBC_RST_FEEDBACK    3'h7
`define LBC_RST_AF_THRESH   8'hcf
`define LBC_RST_ZERO_DET    1'h1
`define LBC_RST_PWM_POL     1'h1

// ramp durations in microseconds, code 15 first
`define LBC_RAMP_US_C0      27'h0000800
`define LBC_RAMP_US_TABLE {27'h7000000, 27'h6000000, 27'h5000000, 27'h4000000, \
   27'h3800000, 27'h3000000, 27'h2800000, 27'h2000000, 27'h1000000, 27'h0800000, \
   27'h0400000, 27'h0200000, 27'h0100000, 27'h0080000, 27'h0040000, `LBC_RAMP_US_C0}

`endif

// ---- design/lbc_pkg.sv ----
package lbc_pkg;
`include "lbc_defines.svh"

   // decoded configuration handed to the analog side
   typedef struct packed {
      logic [2:0] sink_bank;        // 1 = string on bank b
      logic [7:0] ramp_a;           // start-up / shutdown codes, bank a
      logic [7:0] ramp_b;           // start-up / shutdown codes, bank b
      logic [7:0] rt_ramp;          // shared run-time up / down codes
      logic [3:0] rt_sel;           // [3:2] bank b, [1:0] bank a
      logic       dither_off_b;
      logic       dither_off_a;
      logic       map_linear;
      logic [4:0] full_scale_a;
      logic [4:0] full_scale_b;
      logic [2:0] feedback_en;      // string anode tied to boost output
      logic       auto_headroom;
      logic       auto_freq;
      logic [1:0] overvoltage_sel;  // 16/24/32/40 volt
      logic       freq_1mhz;
      logic [7:0] af_thresh;
      logic       zero_det;
      logic       pwm_act_high;
      logic       pwm_scale_b;
      logic       pwm_scale_a;
   } lbc_cfg_t;

   // effective ramp durations of one bank
   typedef struct packed {
      logic [26:0] up_us;
      logic [26:0] down_us;
   } lbc_ramp_t;

   // synchronised pin events
   typedef struct packed {
      logic scl_rise;
      logic scl_fall;
      logic start;
      logic stop;
      logic sda;
   } lbc_pin_evt_t;

   // serial slave states
   typedef enum logic [2:0] {
      ST_IDLE, ST_DEV, ST_REG, ST_WR, ST_RD, ST_ACK, ST_MACK
   } lbc_state_t;

   localparam lbc_cfg_t LBC_CFG_RST = '{
      sink_bank: `LBC_RST_SINK, full_scale_a: `LBC_RST_FULL_SCALE,
      full_scale_b: `LBC_RST_FULL_SCALE, feedback_en: `LBC_RST_FEEDBACK,
      af_thresh: `LBC_RST_AF_THRESH, zero_det: `LBC_RST_ZERO_DET,
      pwm_act_high: `LBC_RST_PWM_POL, default: '0};

   localparam logic [431:0] LBC_RAMP_TBL = `LBC_RAMP_US_TABLE;

   // ramp code to duration lookup
   function automatic logic [26:0] lbc_ramp_us(input logic [3:0] code);
      return LBC_RAMP_TBL[27*code +: 27];
   endfunction : lbc_ramp_us

endpackage : lbc_pkg

// ---- design/lbc_pin_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module lbc_pin_sync
   import lbc_pkg::*;
(
   // clock, reset, enable
   input  wire logic   i_clk,
   input  wire logic   i_rst_n,
   input  wire logic   i_ce,
   // raw pins
   input  wire logic   i_scl,
   input  wire logic   i_sda,
   // events
   output lbc_pin_evt_t o_evt
);
   // [0] meta, [1] synced, [2] previous synced
   logic [2:0] scl_q;
   logic [2:0] sda_q;

   // idle bus is high, so reset to ones to avoid a false start
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scl_q <= 3'h7;
         sda_q <= 3'h7;
      end else if (i_ce) begin
         scl_q <= {scl_q[1:0], i_scl};
         sda_q <= {sda_q[1:0], i_sda};
      end
   end

   // edges only look at stages 1 and 2, never the meta stage
   assign o_evt.scl_rise = scl_q[1] & ~scl_q[2];
   assign o_evt.scl_fall = ~scl_q[1] & scl_q[2];
   assign o_evt.start    = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
   assign o_evt.stop     = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
   assign o_evt.sda      = sda_q[1];
endmodule : lbc_pin_sync
`default_nettype wire

// ---- sim/lbc_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module lbc_host_model (
   // clock and device pins
   input  wire logic i_clk,
   input  wire logic i_sda_out,
   input  wire logic i_sda_oen_n,
   // bus pins
   output logic      o_scl,
   output logic      o_sda
);
   logic sda_drv = 1'b1;  // 1 = host releases the line
   initial o_scl = 1'b1;
   // open drain with pull-up: any party may pull low
   assign o_sda = sda_drv & (i_sda_oen_n | i_sda_out);

   // wait n clocks, then step off the edge
   task automatic hw(input int n);
      repeat (n) @(posedge i_clk);
      #2;
   endtask : hw

   // sda moves only while scl is low
   task automatic bit_io(input logic b, output logic s);
      sda_drv = b;
      hw(6);
      o_scl = 1'b1;
      hw(6);
      s = o_sda;
      o_scl = 1'b0;
      hw(2);
   endtask : bit_io

   // start or repeated start
   task automatic start_c();
      sda_drv = 1'b1;
      hw(6);
      o_scl = 1'b1;
      hw(6);
      sda_drv = 1'b0;
      hw(6);
      o_scl = 1'b0;
      hw(2);
   endtask : start_c

   task automatic stop_c();
      sda_drv = 1'b0;
      hw(6);
      o_scl = 1'b1;
      hw(6);
      sda_drv = 1'b1;
      hw(6);
   endtask : stop_c

   // msb first, ninth bit is the acknowledge
   task automatic xfer(input logic [7:0] d, input logic mack,
                       output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], q[i]);
      bit_io(mack, ack);
   endtask : xfer

   // target, register byte, data byte
   task automatic wr(input logic [6:0] t, input logic [7:0] r, d, output logic ok);
      logic       a0, a1, a2;
      logic [7:0] x;
      start_c();
      xfer({t, 1'b0}, 1'b1, x, a0);
      xfer(r, 1'b1, x, a1);
      xfer(d, 1'b1, x, a2);
      stop_c();
      ok = !(a0 | a1 | a2);
   endtask : wr

   // pointer write, repeated start, one byte read with nack
   task automatic rd(input logic [7:0] r, output logic [7:0] q, output logic ok);
      logic       a0, a1, a2, n;
      logic [7:0] x;
      start_c();
      xfer(8'h6c, 1'b1, x, a0);
      xfer(r, 1'b1, x, a1);
      start_c();
      xfer(8'h6d, 1'b1, x, a2);
      xfer(8'hff, 1'b1, q, n);
      stop_c();
      ok = !(a0 | a1 | a2);
   endtask : rd
endmodule : lbc_host_model
`default_nettype wire

// ---- sim/test_led_bank_config_registers.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CMP(nm, e, g) begin \
   n_compared++; \
   if ((g) !== (e)) begin \
      $display("unexpected %s expected %h seen %h", nm, e, g); \
      fail_count++; \
   end \
end
module test_led_bank_config_registers import lbc_pkg::*;;
   logic            mclk = 1'b0;
   logic            rstn = 1'b0;
   logic            scl, sda, sda_out, sda_oen_n, load, frozen_ok;
   logic            ce = 1'b1;       // clock enable into the block
   lbc_cfg_t        cfg;
   lbc_ramp_t [1:0] ramp;
   logic [10:0]     bright;
   logic [7:0]      m [256];         // model register image
   logic [10:0]     exp_bright = '0;
   int              loads = 0, exp_loads = 0, fail_count = 0, n_compared = 0;
   // writes 0x20 before 0x21, plus two unmapped places
   logic [7:0] offs [16] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h16, 8'h17, 8'h18,
      8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h20, 8'h21, 8'h15, 8'h30};
   always #20 mclk = ~mclk;
   // count on the falling edge, where the pulse has settled
   always @(negedge mclk) if (load === 1'b1) loads++;

   lbc_cfg_regs u_dut (.i_mclk(mclk), .i_rstn(rstn), .i_ce(ce), .i_scl(scl),
      .i_sda(sda), .o_sda_out(sda_out), .o_sda_oen_n(sda_oen_n), .o_cfg(cfg),
      .o_ramp(ramp), .o_bank_a_brightness(bright), .o_bright_load(load));
   lbc_host_model u_host (.i_clk(mclk), .i_sda_out(sda_out),
      .i_sda_oen_n(sda_oen_n), .o_scl(scl), .o_sda(sda));

   // writable bits per offset, everything else reads zero
   function automatic logic [7:0] wmask(input logic [7:0] a);
      case (a)
         8'h10, 8'h19, 8'h20: return 8'h07;
         8'h11, 8'h12, 8'h13, 8'h1b, 8'h21: return 8'hff;
         8'h14, 8'h1c: return 8'h0f;
         8'h16: return 8'h0d;
         8'h17, 8'h18, 8'h1a: return 8'h1f;
         default: return 8'h00;
      endcase
   endfunction : wmask

   // code to microseconds: doubling to code 8, then linear steps
   function automatic int ramp_us(input int c);
      if (c == 0) return 2048;
      if (c <= 8) return 262144 << (c - 1);
      if (c <= 12) return 33554432 + (c - 8) * 8388608;
      return 67108864 + (c - 12) * 16777216;
   endfunction : ramp_us

   task automatic chk_all();
      lbc_cfg_t   e;
      logic [1:0] s;
      logic [7:0] c;
      e = {m[8'h10][2:0], m[8'h11], m[8'h12], m[8'h13], m[8'h14][3:0], m[8'h16][3:2],
         m[8'h16][0], m[8'h17][4:0], m[8'h18][4:0], m[8'h19][2:0], m[8'h1a][4:0],
         m[8'h1b], m[8'h1c][3:0]};
      `CMP("cfg", e, cfg)
      for (int b = 0; b < 2; b++) begin
         s = m[8'h14][2*b +: 2];
         c = s[0] ? m[8'h11 + b] : m[8'h13];
         `CMP("ramp up", s[1] ? 27'h0 : 27'(ramp_us(c[7:4])), ramp[b].up_us)
         `CMP("ramp down", s[1] ? 27'h0 : 27'(ramp_us(c[3:0])), ramp[b].down_us)
      end
      `CMP("brightness", exp_bright, bright)
      `CMP("load pulses", exp_loads, loads)
   endtask : chk_all

   task automatic put(input logic [6:0] t, input logic [7:0] r, d);
      logic ok;
      u_host.wr(t, r, d, ok);
      `CMP("ack", t == 7'h36, ok)
      if (t == 7'h36) begin
         m[r] = d & wmask(r);
         if (r == 8'h21) begin
            exp_bright = {d, m[8'h20][2:0]};
            exp_loads++;
         end
      end
      chk_all();
   endtask : put

   task automatic get(input logic [7:0] r);
      logic       ok;
      logic [7:0] q;
      u_host.rd(r, q, ok);
      `CMP("read ack", 1'b1, ok)
      `CMP("readback", m[r], q)
   endtask : get

   task automatic wrap_up();
      if (fail_count == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up

   initial begin
      void'($urandom(32'h02a71294));
      foreach (m[i])
         m[i] = 8'h00;
      m[8'h10] = 8'h06;
      m[8'h17] = 8'h13;
      m[8'h18] = 8'h13;
      m[8'h19] = 8'h07;
      m[8'h1b] = 8'hcf;
      m[8'h1c] = 8'h0c;
      repeat (4) @(posedge mclk);
      #2 rstn = 1'b1;
      repeat (4) @(posedge mclk);
      chk_all();
      foreach (offs[i])
         get(offs[i]);
      repeat (2) foreach (offs[i]) begin
         // pwm setup only changes with both bank enables off
         if (offs[i] == 8'h1c)
            put(7'h36, 8'h1c, m[8'h1c] & 8'h0c);
         put(7'h36, offs[i], 8'($urandom));
         get(offs[i]);
      end
      // every select code on both banks
      for (int s = 0; s < 4; s++)
         put(7'h36, 8'h14, 8'(s | ((3 - s) << 2)));
      put(7'h37, 8'h21, 8'h5a);
      // a frozen block must neither answer nor store a whole transfer
      ce = 1'b0;
      u_host.wr(7'h36, 8'h10, 8'h01, frozen_ok);
      `CMP("frozen ack", 1'b0, frozen_ok)
      ce = 1'b1;
      repeat (4) @(posedge mclk);
      chk_all();
      wrap_up();
   end

   // hang guard, about 1.4 times the expected run
   initial begin
      repeat (60000) @(posedge mclk);
      fail_count++;
      wrap_up();
   end
endmodule : test_led_bank_config_registers
`default_nettype wire
